// ### verilog/user_break_unit.sv
// User break unit: condition registers, match logic and AXI4-Lite slave.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`include "user_break_cfg.svh"

module user_break_unit (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // AXI4-Lite write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [11:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [11:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Observed bus cycle
  input wire user_break_pkg::bus_cycle_t i_cycle,
  // Interrupt controller handshake
  output logic o_break_req,
  input wire logic i_break_ack,
  // Interrupt line
  output logic o_irq
);

  logic [15:0] addr_high_r;
  logic [15:0] addr_low_r;
  logic [15:0] mask_high_r;
  logic [15:0] mask_low_r;
  logic [15:0] qual_r;
  logic irq_status_r;
  logic irq_mask_r;
  logic break_req_r;
  logic aw_held_r;
  logic w_held_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  user_break_pkg::rd_state_t rd_state_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_fire;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_known;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel capture: address and data may arrive in either order.
  assign o_awready = !aw_held_r && !bvalid_r;
  assign o_wready = !w_held_r && !bvalid_r;
  assign wr_addr = aw_held_r ? aw_addr_r : i_awaddr;
  assign wr_data = w_held_r ? w_data_r : i_wdata;
  assign wr_strb = w_held_r ? w_strb_r : i_wstrb;
  assign wr_fire = (aw_held_r || (i_awvalid && o_awready)) &&
                   (w_held_r || (i_wvalid && o_wready)) && !bvalid_r;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= i_wdata;
        w_strb_r <= i_wstrb;
      end
    end
  end

  always_comb begin
    case (wr_addr & 12'hFFC)
      `UB_OFF_ADDR_HIGH, `UB_OFF_ADDR_LOW, `UB_OFF_MASK_HIGH, `UB_OFF_MASK_LOW,
      `UB_OFF_QUALIFIER, `UB_OFF_IRQ_STATUS, `UB_OFF_IRQ_MASK: wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= `UB_AXI_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_known ? `UB_AXI_OKAY : `UB_AXI_SLVERR;
    end else if (i_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Condition registers; byte lanes 0 and 1 carry the 16-bit contents.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // No standby input exists, so contents change only on reset or a write.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_high_r <= `UB_REG_RESET;
      addr_low_r <= `UB_REG_RESET;
    end else if (wr_fire) begin
      if ((wr_addr & 12'hFFC) == `UB_OFF_ADDR_HIGH) begin
        addr_high_r <= merge16(addr_high_r, wr_data, wr_strb);
      end
      if ((wr_addr & 12'hFFC) == `UB_OFF_ADDR_LOW) begin
        addr_low_r <= merge16(addr_low_r, wr_data, wr_strb);
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_high_r <= `UB_REG_RESET;
      mask_low_r <= `UB_REG_RESET;
    end else if (wr_fire) begin
      if ((wr_addr & 12'hFFC) == `UB_OFF_MASK_HIGH) begin
        mask_high_r <= merge16(mask_high_r, wr_data, wr_strb);
      end
      if ((wr_addr & 12'hFFC) == `UB_OFF_MASK_LOW) begin
        mask_low_r <= merge16(mask_low_r, wr_data, wr_strb);
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      qual_r <= `UB_REG_RESET;
    end else if (wr_fire && (wr_addr & 12'hFFC) == `UB_OFF_QUALIFIER) begin
      qual_r <= merge16(qual_r, wr_data, wr_strb) & `UB_QUAL_WRITE_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Break condition matching against registered contents.
  logic [31:0] brk_addr;
  logic [31:0] brk_mask;
  logic addr_hit;
  logic src_hit;
  logic kind_hit;
  logic dir_hit;
  logic size_hit;
  logic cond_hit;
  user_break_pkg::op_size_t eff_size;

  assign brk_addr = {addr_high_r, addr_low_r};
  assign brk_mask = {mask_high_r, mask_low_r};
  assign addr_hit = ((i_cycle.addr ^ brk_addr) & ~brk_mask) == 32'h0000_0000;
  assign src_hit = i_cycle.is_dma ? qual_r[`UB_SRC_HI] : qual_r[`UB_SRC_LO];
  assign kind_hit = i_cycle.is_fetch ? qual_r[`UB_KIND_LO] : qual_r[`UB_KIND_HI];
  assign dir_hit = i_cycle.is_write ? qual_r[`UB_DIR_HI] : qual_r[`UB_DIR_LO];
  // Fetches are words; data uses the transfer's own operand size.
  assign eff_size = i_cycle.is_fetch ? user_break_pkg::SIZE_WORD : i_cycle.size;
  assign size_hit = (qual_r[`UB_SIZE_HI:`UB_SIZE_LO] == 2'b00) ||
                    (qual_r[`UB_SIZE_HI:`UB_SIZE_LO] == eff_size);
  // A zero source, kind or direction field clears its own hit term, so no break can follow.
  assign cond_hit = i_cycle.valid && addr_hit && src_hit && kind_hit &&
                    dir_hit && size_hit;

  // The request holds until the interrupt controller takes it; a new hit wins.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      break_req_r <= 1'b0;
    end else if (cond_hit) begin
      break_req_r <= 1'b1;
    end else if (i_break_ack) begin
      break_req_r <= 1'b0;
    end
  end

  assign o_break_req = break_req_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sticky interrupt status and mask.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_status_r <= 1'b0;
      irq_mask_r <= 1'b0;
    end else begin
      if (cond_hit) begin
        irq_status_r <= 1'b1;
      end else if (wr_fire && (wr_addr & 12'hFFC) == `UB_OFF_IRQ_STATUS &&
                   wr_strb[0] && wr_data[0]) begin
        irq_status_r <= 1'b0;
      end
      if (wr_fire && (wr_addr & 12'hFFC) == `UB_OFF_IRQ_MASK && wr_strb[0]) begin
        irq_mask_r <= wr_data[0];
      end
    end
  end

  assign o_irq = irq_status_r && irq_mask_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read channel.
  logic [31:0] rd_word;
  logic rd_known;

  always_comb begin
    rd_known = 1'b1;
    case (i_araddr & 12'hFFC)
      `UB_OFF_ADDR_HIGH: rd_word = {16'h0000, addr_high_r};
      `UB_OFF_ADDR_LOW: rd_word = {16'h0000, addr_low_r};
      `UB_OFF_MASK_HIGH: rd_word = {16'h0000, mask_high_r};
      `UB_OFF_MASK_LOW: rd_word = {16'h0000, mask_low_r};
      `UB_OFF_QUALIFIER: rd_word = {16'h0000, qual_r & `UB_QUAL_WRITE_MASK};
      `UB_OFF_IRQ_STATUS: rd_word = {31'h0000_0000, irq_status_r};
      `UB_OFF_IRQ_MASK: rd_word = {31'h0000_0000, irq_mask_r};
      default: begin
        rd_word = 32'h0000_0000;
        rd_known = 1'b0;
      end
    endcase
  end

  assign o_arready = (rd_state_r == user_break_pkg::RD_IDLE);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_state_r <= user_break_pkg::RD_IDLE;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `UB_AXI_OKAY;
    end else begin
      case (rd_state_r)
        user_break_pkg::RD_IDLE: begin
          if (i_arvalid) begin
            rd_state_r <= user_break_pkg::RD_RESP;
            rdata_r <= rd_word;
            rresp_r <= rd_known ? `UB_AXI_OKAY : `UB_AXI_SLVERR;
          end
        end
        user_break_pkg::RD_RESP: begin
          if (i_rready) begin
            rd_state_r <= user_break_pkg::RD_IDLE;
          end
        end
        default: rd_state_r <= user_break_pkg::RD_IDLE;
      endcase
    end
  end

  assign o_rvalid = (rd_state_r == user_break_pkg::RD_RESP);
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  property p_hit_sets_req;
    @(posedge i_mclk) disable iff (!i_rst_n) cond_hit |=> o_break_req;
  endproperty
  a_hit_sets_req: assert property (p_hit_sets_req) else $error("hit lost");

  property p_req_pending;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (o_break_req && !i_break_ack) |=> o_break_req;
  endproperty
  a_req_pending: assert property (p_req_pending) else $error("request dropped");

  property p_zero_field_no_req;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (!o_break_req && (qual_r[7:6] == 2'b00 || qual_r[5:4] == 2'b00 ||
       qual_r[3:2] == 2'b00)) |=> !o_break_req;
  endproperty
  a_zero_field_no_req: assert property (p_zero_field_no_req) else $error("break not off");

  property p_qual_reserved_zero;
    @(posedge i_mclk) disable iff (!i_rst_n) qual_r[15:8] == 8'h00;
  endproperty
  a_qual_reserved_zero: assert property (p_qual_reserved_zero) else $error("reserved set");

  property p_addr_high_write;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (wr_fire && (wr_addr & 12'hFFC) == `UB_OFF_ADDR_HIGH && wr_strb == 4'hF)
      |=> addr_high_r == $past(wr_data[15:0]);
  endproperty
  a_addr_high_write: assert property (p_addr_high_write) else $error("high addr");

  property p_addr_low_write;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (wr_fire && (wr_addr & 12'hFFC) == `UB_OFF_ADDR_LOW && wr_strb == 4'hF)
      |=> addr_low_r == $past(wr_data[15:0]);
  endproperty
  a_addr_low_write: assert property (p_addr_low_write) else $error("low addr");

  property p_fetch_byte_never;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (i_cycle.is_fetch && qual_r[1:0] == 2'b01) |-> !cond_hit;
  endproperty
  a_fetch_byte_never: assert property (p_fetch_byte_never) else $error("fetch not word");

  property p_masked_all_hit;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (brk_mask == 32'hFFFF_FFFF && qual_r == 16'h00EF && i_cycle.valid && !i_cycle.is_fetch
       && i_cycle.size == user_break_pkg::SIZE_LONG) |-> ##1 o_break_req;
  endproperty
  a_masked_all_hit: assert property (p_masked_all_hit) else $error("mask ignored");

  property p_bresp_follows;
    @(posedge i_mclk) disable iff (!i_rst_n) wr_fire |=> o_bvalid;
  endproperty
  a_bresp_follows: assert property (p_bresp_follows) else $error("no bvalid");

  property p_hit_sets_status;
    @(posedge i_mclk) disable iff (!i_rst_n) cond_hit |=> irq_status_r;
  endproperty
  a_hit_sets_status: assert property (p_hit_sets_status) else $error("status lost");

  property p_ack_clears_req;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (o_break_req && i_break_ack && !cond_hit) |=> !o_break_req;
  endproperty
  a_ack_clears_req: assert property (p_ack_clears_req) else $error("request stuck");

  property p_regs_kept;
    @(posedge i_mclk) disable iff (!i_rst_n)
      !wr_fire |=> $stable({addr_high_r, addr_low_r, mask_high_r, mask_low_r, qual_r});
  endproperty
  a_regs_kept: assert property (p_regs_kept) else $error("register drifted");

endmodule

// ### verilog/user_break_cfg.svh
// Register offsets, field positions and reset values of the user break unit.
`ifndef USER_BREAK_CFG_SVH
`define USER_BREAK_CFG_SVH
`define UB_OFF_ADDR_HIGH 12'h000
`define UB_OFF_ADDR_LOW 12'h004
`define UB_OFF_MASK_HIGH 12'h008
`define UB_OFF_MASK_LOW 12'h00C
`define UB_OFF_QUALIFIER 12'h010
`define UB_OFF_IRQ_STATUS 12'h014
`define UB_OFF_IRQ_MASK 12'h018
`define UB_REG_RESET 16'h0000
`define UB_QUAL_WRITE_MASK 16'h00FF
`define UB_SRC_HI 7
`define UB_SRC_LO 6
`define UB_KIND_HI 5
`define UB_KIND_LO 4
`define UB_DIR_HI 3
`define UB_DIR_LO 2
`define UB_SIZE_HI 1
`define UB_SIZE_LO 0
`define UB_AXI_OKAY 2'b00
`define UB_AXI_SLVERR 2'b10
`endif

// ### verilog/user_break_pkg.sv
// Types shared by the user break unit and its environment.
package user_break_pkg;
  typedef enum logic [1:0] {
    SIZE_ANY,
    SIZE_BYTE,
    SIZE_WORD,
    SIZE_LONG
  } op_size_t;

  typedef struct packed {
    logic valid;
    logic is_dma;
    logic is_fetch;
    logic is_write;
    op_size_t size;
    logic [31:0] addr;
  } bus_cycle_t;

  typedef enum {
    RD_IDLE,
    RD_RESP
  } rd_state_t;
endpackage

// ### dv/break_interrupt_controller_unit_model.sv
// Behavioural interrupt controller that accepts the break request after a set delay.
`timescale 1ns/10ps

module break_interrupt_controller_unit_model (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Request and acceptance delay
  input wire logic i_break_req,
  input wire logic [3:0] i_hold,
  // Acceptance pulse
  output logic o_break_ack
);
  logic [3:0] wait_r;

  ////////////////////////////////////////////////////////////////////////////////
  // A long delay stands for a mask level that keeps the request waiting.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_r <= 4'h0;
      o_break_ack <= 1'b0;
    end else begin
      o_break_ack <= i_break_req && !o_break_ack && wait_r == i_hold;
      wait_r <= (i_break_req && !o_break_ack && wait_r != i_hold) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule

// ### dv/user_break_unit_tb.sv
// Self-checking testbench of the user break unit.
`timescale 1ns/10ps
`include "user_break_cfg.svh"

module user_break_unit_tb;
  logic i_mclk = 1'b0;
  logic i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_break_ack;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_break_req, o_irq;
  logic [11:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, ba_m, bm_m, r, r2, a;
  logic [3:0] i_wstrb, hold;
  logic [1:0] o_bresp, o_rresp;
  logic [7:0] q_m;
  logic stat_m, irqm_m;
  user_break_pkg::bus_cycle_t i_cycle;
  logic [33:0] exp_q[$];
  int num_errors = 0;
  int checks_done = 0;
  int seed = 32'hb433_0219;
  int waited, k, p, j;

  always #2 i_mclk = ~i_mclk;

  user_break_unit i_dut (.i_mclk, .i_rst_n, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid,
    .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready,
    .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_cycle, .o_break_req, .i_break_ack,
    .o_irq);

  break_interrupt_controller_unit_model i_interrupt_controller_unit (.i_mclk, .i_rst_n, .i_break_req(o_break_req), .i_hold(hold),
    .o_break_ack(i_break_ack));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic hit(input logic dma, fe, wr, input logic [1:0] sz,
                               input logic [31:0] ad);
    logic [1:0] es;
    es = fe ? 2'h2 : sz;
    return (dma ? q_m[7] : q_m[6]) && (fe ? q_m[4] : q_m[5]) && (wr ? q_m[3] : q_m[2]) &&
      (q_m[1:0] == 2'h0 || q_m[1:0] == es) && (((ad ^ ba_m) & ~bm_m) == 32'h0000_0000);
  endfunction

  // One register access; the response is judged by the watcher below.
  task automatic xfer(input logic rd, input logic [11:0] ad, input logic [31:0] d,
                      input logic [1:0] rs);
    logic ta, tw, rv;
    int n;
    exp_q.push_back({rs, rd ? d : 32'h0000_0000});
    @(posedge i_mclk);
    if (rd) begin
      i_arvalid <= 1'b1;
      i_araddr <= ad;
      i_rready <= 1'b1;
    end else begin
      i_awvalid <= 1'b1;
      i_awaddr <= ad;
      i_wvalid <= 1'b1;
      i_wdata <= d;
      i_wstrb <= 4'hf;
      i_bready <= 1'b1;
    end
    n = 0;
    rv = 1'b0;
    while (!rv && n < 50) begin
      @(negedge i_mclk);
      ta = (i_arvalid && o_arready) || (i_awvalid && o_awready);
      tw = i_wvalid && o_wready;
      rv = rd ? o_rvalid : o_bvalid;
      @(posedge i_mclk);
      if (ta) begin
        i_arvalid <= 1'b0;
        i_awvalid <= 1'b0;
      end
      if (tw) begin
        i_wvalid <= 1'b0;
      end
      if (rv) begin
        i_rready <= 1'b0;
        i_bready <= 1'b0;
      end
      n++;
    end
    if (!rv) begin
      num_errors++;
      complete_run();
    end
  endtask

  // One observed bus cycle, then the request is followed until it is accepted.
  task automatic cyc(input logic dma, fe, wr, input logic [1:0] sz, input logic [31:0] ad);
    logic e;
    e = hit(dma, fe, wr, sz, ad);
    @(posedge i_mclk);
    i_cycle <= {1'b1, dma, fe, wr, sz, ad};
    @(posedge i_mclk);
    i_cycle <= {1'b0, ~{dma, fe, wr, sz, ad}};
    #1;
    stat_m = stat_m | e;
    chk(o_break_req, e);
    chk(o_irq, stat_m & irqm_m);
    waited = 0;
    while (o_break_req === 1'b1 && waited < 60) begin
      @(posedge i_mclk);
      #1;
      waited++;
    end
    if (waited >= 60) begin
      num_errors++;
      complete_run();
    end
  endtask

  always @(posedge i_mclk) begin
    if ((o_rvalid && i_rready) || (o_bvalid && i_bready)) begin
      if (exp_q.size() == 0) begin
        chk(1'b1, 1'b0);
      end else begin
        chk(o_rvalid ? {o_rresp, o_rdata} : {o_bresp, 32'h0000_0000}, exp_q.pop_front());
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_rst_n = 1'b0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    {i_awaddr, i_araddr, i_wdata, i_wstrb} = 60'h0;
    i_cycle = '0;
    hold = 4'h0;
    {stat_m, irqm_m, q_m, ba_m, bm_m} = 74'h0;
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    for (k = 0; k < 8; k++) begin
      xfer(1'b1, 12'(k * 4), 32'h0000_0000, k == 7 ? `UB_AXI_SLVERR : `UB_AXI_OKAY);
    end
    xfer(1'b0, 12'h01C, 32'hFFFF_FFFF, `UB_AXI_SLVERR);
    for (p = 0; p < 2; p++) begin
      ba_m = $random(seed);
      r = $random(seed);
      bm_m = p ? 32'hFFFF_0000 : (r & $random(seed));
      for (j = 0; j < 4; j++) begin
        r = $random(seed);
        r2 = {16'h0000, j[1] ? (j[0] ? bm_m[15:0] : bm_m[31:16]) :
              (j[0] ? ba_m[15:0] : ba_m[31:16])};
        xfer(1'b0, 12'(j * 4), {r[31:16], r2[15:0]}, `UB_AXI_OKAY);
        xfer(1'b1, 12'(j * 4), r2, `UB_AXI_OKAY);
      end
      for (k = 0; k < 256; k++) begin
        q_m = k[7:0];
        q_m[0] = q_m[0] & ~q_m[4];
        xfer(1'b0, `UB_OFF_QUALIFIER, {24'h00_0000, q_m}, `UB_AXI_OKAY);
        r = $random(seed);
        r2 = $random(seed);
        hold <= r[12:9];
        a = ba_m ^ (r2 & bm_m) ^ (r[8] ? 32'h0000_0001 << r[4:0] : 32'h0000_0000);
        cyc(r[0], r[1] & ~r[0], r[2] & ~(r[1] & ~r[0]), r[6:5], a);
      end
    end
    xfer(1'b1, `UB_OFF_QUALIFIER, {24'h00_0000, q_m}, `UB_AXI_OKAY);
    q_m = 8'h54;
    hold <= 4'hF;
    xfer(1'b0, `UB_OFF_QUALIFIER, {24'h00_0000, q_m}, `UB_AXI_OKAY);
    xfer(1'b0, `UB_OFF_IRQ_STATUS, 32'h0000_0001, `UB_AXI_OKAY);
    stat_m = 1'b0;
    xfer(1'b0, `UB_OFF_IRQ_MASK, 32'h0000_0001, `UB_AXI_OKAY);
    irqm_m = 1'b1;
    cyc(1'b0, 1'b1, 1'b0, 2'h1, ba_m ^ 32'hA5A5_0000);
    chk(waited > 14, 1'b1);
    xfer(1'b1, `UB_OFF_IRQ_STATUS, 32'h0000_0001, `UB_AXI_OKAY);
    xfer(1'b0, `UB_OFF_IRQ_STATUS, 32'h0000_0001, `UB_AXI_OKAY);
    stat_m = 1'b0;
    #1;
    chk(o_irq, 1'b0);
    xfer(1'b0, `UB_OFF_IRQ_MASK, 32'h0000_0000, `UB_AXI_OKAY);
    irqm_m = 1'b0;
    cyc(1'b0, 1'b1, 1'b0, 2'h3, ba_m);
    for (j = 2; j < 4; j++) begin
      xfer(1'b0, 12'(j * 4), 32'h0000_FFFF, `UB_AXI_OKAY);
    end
    bm_m = 32'hFFFF_FFFF;
    q_m = 8'hEF;
    xfer(1'b0, `UB_OFF_QUALIFIER, {24'h00_0000, q_m}, `UB_AXI_OKAY);
    r = $random(seed);
    cyc(1'b1, 1'b0, 1'b0, 2'h3, r);
    xfer(1'b1, `UB_OFF_IRQ_STATUS, 32'h0000_0001, `UB_AXI_OKAY);
    complete_run();
  end
endmodule
